// file: core/mcf_rx.sv
`timescale 1ns/1ps
module mcf_rx
    import mcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    mcf_link_if.rx lk
);
    typedef struct packed {
        mcf_rxst_t st;
        logic [8:0] sh;
        logic [3:0] cnt;
        logic load;
        logic [7:0] data;
        logic perr;
    } mcf_rx_t;

    mcf_rx_t s;
    mcf_rx_t n;
    logic [3:0] dn;
    logic [3:0] want;

    assign dn = lk.eight_bits ? DATA_BITS_8 : DATA_BITS_7;
    assign want = lk.async_mode ? dn + (lk.par_en ? PAR_BITS : 4'h0) : SYNC_BITS;
    assign lk.rx_load = s.load;
    assign lk.rx_data = s.data;
    assign lk.rx_perr = s.perr;

    always_comb
    begin
        n = s;
        n.load = 1'b0;
        if (lk.baud_tick)
        begin
            case (s.st)
                R_HUNT:
                begin
                    n.sh = '0;
                    if (!lk.async_mode)
                    begin
                        n.sh[0] = lk.rx_bit;
                        n.cnt = 4'h1;
                        n.st = R_DATA;
                    end
                    else if (lk.rx_bit == SPACE)
                    begin
                        n.cnt = 4'h0;
                        n.st = R_DATA;
                    end
                end
                R_DATA:
                begin
                    n.sh[s.cnt] = lk.rx_bit;
                    n.cnt = s.cnt + 4'h1;
                    if (n.cnt == want)
                    begin
                        n.load = 1'b1;
                        n.data = (lk.eight_bits || !lk.async_mode) ? n.sh[7:0]
                            : {1'b0, n.sh[6:0]};
                        n.perr = lk.async_mode && lk.par_en
                            && ((^n.data) ^ lk.par_odd ^ n.sh[dn]);
                        n.cnt = 4'h0;
                        // In async mode any run of mark may follow before the next start; sync goes straight on
                        n.st = lk.async_mode ? R_HUNT : R_DATA;
                    end
                end
                default:
                    n.st = R_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '{st: R_HUNT, sh: '0, cnt: 4'h0, load: 1'b0, data: 8'h00, perr: 1'b0};
        else
            s <= n;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_start_seen;
        s.st == R_HUNT && lk.baud_tick && lk.async_mode && lk.rx_bit == SPACE;
    endsequence

    a_start_hunt: assert property (seq_start_seen |=> s.st == R_DATA && s.cnt == 4'h0)
        else $error("start bit not taken");
    a_mark_idle: assert property (s.st == R_HUNT && lk.baud_tick && lk.async_mode
        && lk.rx_bit |=> s.st == R_HUNT && !s.load)
        else $error("mark between characters not ignored");
    a_perr_cause: assert property (s.load && s.perr |-> lk.async_mode && lk.par_en)
        else $error("parity error without parity");
    a_sync_count: assert property (s.load && !lk.async_mode |-> $past(s.cnt) == 4'h7)
        else $error("sync byte not eight bits");
endmodule

// file: core/mcf_top.sv
`timescale 1ns/1ps
module mcf_top
    import mcf_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cbus_sel_n_i,
    input wire logic cbus_clk_i,
    input wire logic cbus_cmd_i,
    output logic cbus_reply_o,
    output logic cbus_reply_oe_n_o,
    input wire logic rx_bit_i,
    output logic tx_bit_o,
    output logic relay_pulldown_pin_o,
    output logic relay_pulldown_pin_oe_n_o,
    output logic detection_mode_high_o,
    output logic detection_mode_low_o
);
    typedef struct packed {
        logic [2:0] sync0;
        logic [2:0] sync1;
        logic sclk_d;
        mcf_cbus_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] addr;
        logic [7:0] reply;
        logic oe;
        logic [7:0] setup;
        logic [7:0] txdata;
        logic [7:0] mode;
        logic txon;
        logic tx_full;
        logic [7:0] rxdata;
        logic rx_rdy;
        logic ufl;
        logic ofl;
        logic perr;
        logic [BAUD_W-1:0] baud_cnt;
        logic tick;
    } mcf_top_t;

    localparam logic [BAUD_W-1:0] BAUD_LAST = BAUD_W'(BAUD_DIV - 1);

    mcf_top_t s;
    mcf_top_t n;
    logic rise;
    logic fall;
    logic sel_n;
    logic cmd;
    logic [7:0] shifted;
    logic [7:0] flags;
    logic wr_txdata;
    logic rst_cmd;

    mcf_link_if lk();

    mcf_tx u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lk(lk.tx)
    );

    mcf_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lk(lk.rx)
    );

    // Synchronised host pins, edges found from the second stage on
    assign rise = s.sync1[2] && !s.sclk_d;
    assign fall = !s.sync1[2] && s.sclk_d;
    assign sel_n = s.sync1[1];
    assign cmd = s.sync1[0];
    assign shifted = {s.sh[6:0], cmd};

    always_comb
    begin
        flags = 8'h00;
        flags[FLG_TXRDY] = !s.tx_full;
        flags[FLG_UFL] = s.ufl;
        flags[FLG_RXRDY] = s.rx_rdy;
        flags[FLG_OFL] = s.ofl;
        flags[FLG_PERR] = s.perr;
    end

    assign wr_txdata = (s.st == C_WDATA) && rise && (s.cnt == CBUS_BITS - 4'h1)
        && (s.addr == ADR_TXDATA);
    assign rst_cmd = (s.st == C_IDLE || s.st == C_ADDR) && rise && !sel_n
        && (s.cnt == CBUS_BITS - 4'h1) && (shifted == ADR_RESET);

    assign lk.baud_tick = s.tick;
    assign lk.async_mode = s.mode[MODE_ASYNC];
    assign lk.eight_bits = s.mode[MODE_EIGHT];
    assign lk.par_en = s.mode[MODE_PEN];
    assign lk.par_odd = s.mode[MODE_PODD];
    assign lk.stop_sel = {s.mode[MODE_STOPB], s.mode[MODE_STOPA]};
    assign lk.tx_en = s.txon;
    assign lk.tx_avail = s.tx_full;
    assign lk.tx_data = s.txdata;
    assign lk.rx_bit = rx_bit_i;

    always_comb
    begin
        n = s;
        n.tick = 1'b0;
        n.sync0 = {cbus_clk_i, cbus_sel_n_i, cbus_cmd_i};
        n.sync1 = s.sync0;
        n.sclk_d = s.sync1[2];

        if (s.baud_cnt == BAUD_LAST)
        begin
            n.baud_cnt = '0;
            n.tick = 1'b1;
        end
        else
            n.baud_cnt = s.baud_cnt + BAUD_W'(1);

        if (lk.tx_take)
            n.tx_full = 1'b0;

        if (sel_n)
        begin
            n.st = C_IDLE;
            n.cnt = 4'h0;
            n.oe = 1'b0;
        end
        else
        begin
            case (s.st)
                C_IDLE, C_ADDR:
                begin
                    n.st = C_ADDR;
                    if (rise)
                    begin
                        n.sh = shifted;
                        n.cnt = s.cnt + 4'h1;
                        if (s.cnt == CBUS_BITS - 4'h1)
                        begin
                            n.cnt = 4'h0;
                            if (shifted == ADR_RESET)
                            begin
                                n.setup = REG_RST_VAL;
                                n.txdata = REG_RST_VAL;
                                n.mode = REG_RST_VAL;
                                n.txon = REG_RST_VAL[TXPSK_TXON];
                                n.st = C_DONE;
                            end
                            else if (shifted == ADR_FLAGS)
                            begin
                                n.reply = flags;
                                n.ufl = 1'b0;
                                n.ofl = 1'b0;
                                n.perr = 1'b0;
                                n.oe = 1'b1;
                                n.st = C_REPLY;
                            end
                            else if (shifted == ADR_RXDATA)
                            begin
                                n.reply = s.rxdata;
                                n.rx_rdy = 1'b0;
                                n.oe = 1'b1;
                                n.st = C_REPLY;
                            end
                            else
                            begin
                                n.addr = shifted;
                                n.st = C_WDATA;
                            end
                        end
                    end
                end
                C_WDATA:
                begin
                    if (rise)
                    begin
                        n.sh = shifted;
                        n.cnt = s.cnt + 4'h1;
                        if (s.cnt == CBUS_BITS - 4'h1)
                        begin
                            n.st = C_DONE;
                            if (s.addr == ADR_SETUP)
                                n.setup = shifted;
                            else if (s.addr == ADR_TXDATA)
                            begin
                                n.txdata = shifted;
                                n.tx_full = 1'b1;
                            end
                            else if (s.addr == ADR_MODE)
                                n.mode = shifted;
                            else if (s.addr == ADR_TXPSK)
                                n.txon = shifted[TXPSK_TXON];
                        end
                    end
                end
                C_REPLY:
                begin
                    // Count reply clocks; the fall closing the address keeps bit 7
                    if (rise && s.cnt != CBUS_BITS)
                        n.cnt = s.cnt + 4'h1;
                    // Next bit only after a reply clock's fall, steady through high
                    if (fall && s.cnt != 4'h0)
                        n.reply = {s.reply[6:0], 1'b0};
                end
                default:
                    n.st = C_DONE;
            endcase
        end

        // Hardware events win over a clear in the same cycle
        if (lk.tx_underflow)
            n.ufl = 1'b1;
        if (lk.rx_load)
        begin
            n.rxdata = lk.rx_data;
            n.rx_rdy = 1'b1;
            if (s.rx_rdy)
                n.ofl = 1'b1;
            if (lk.rx_perr)
                n.perr = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '{st: C_IDLE, sync0: 3'h2, sync1: 3'h2, sclk_d: 1'b0, txon: 1'b0,
                setup: REG_RST_VAL, txdata: REG_RST_VAL, mode: REG_RST_VAL, default: '0};
        else
            s <= n;
    end

    assign cbus_reply_o = s.reply[7];
    assign cbus_reply_oe_n_o = !s.oe;
    assign tx_bit_o = lk.tx_bit;
    assign relay_pulldown_pin_o = 1'b0;
    assign relay_pulldown_pin_oe_n_o = !s.setup[SETUP_RELAY];
    assign detection_mode_high_o = s.setup[SETUP_DETH];
    assign detection_mode_low_o = s.setup[SETUP_DETL];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_reply_steady;
        s.st == C_REPLY && !fall && !sel_n;
    endsequence

    sequence seq_reply_first;
        s.st == C_REPLY && fall && s.cnt == 4'h0 && !sel_n;
    endsequence

    sequence seq_last_wbit;
        s.st == C_WDATA && rise && s.cnt == CBUS_BITS - 4'h1 && !sel_n;
    endsequence

    a_txrdy_clear: assert property (wr_txdata |=> !flags[FLG_TXRDY])
        else $error("transmit ready stays high after write");
    a_rxrdy_set: assert property (lk.rx_load |=> flags[FLG_RXRDY] && s.rxdata == $past(lk.rx_data))
        else $error("receive ready not set on load");
    a_ovf_set: assert property (lk.rx_load && s.rx_rdy |=> flags[FLG_OFL])
        else $error("overflow not flagged");
    a_reset_cmd: assert property (rst_cmd |=> s.setup == 8'h00 && s.mode == 8'h00 && !s.txon)
        else $error("reset command left register bits set");
    a_reply_steady: assert property (seq_reply_steady |=> $stable(cbus_reply_o))
        else $error("reply changed outside falling edge");
    a_reply_first: assert property (seq_reply_first |=> $stable(cbus_reply_o))
        else $error("reply bit 7 lost before first reply clock");
    a_oe_release: assert property (sel_n |=> cbus_reply_oe_n_o)
        else $error("reply driver still on after deselect");
    a_mode_store: assert property ((seq_last_wbit ##0 s.addr == ADR_MODE) |=> s.mode == $past(shifted))
        else $error("framing mode not stored");
    a_setup_store: assert property ((seq_last_wbit ##0 s.addr == ADR_SETUP) |=> s.setup == $past(shifted))
        else $error("set-up byte not stored");
    a_ufl_set: assert property (lk.tx_underflow |=> flags[FLG_UFL])
        else $error("underflow flag not set");
    a_perr_set: assert property (lk.rx_load && lk.rx_perr |=> flags[FLG_PERR])
        else $error("parity flag not set");
    a_txrdy_back: assert property (lk.tx_take && !wr_txdata |=> flags[FLG_TXRDY])
        else $error("transmit ready not restored after take");
endmodule

// file: core/mcf_tx.sv
`timescale 1ns/1ps
module mcf_tx
    import mcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    mcf_link_if.tx lk
);
    typedef struct packed {
        mcf_txst_t st;
        logic [FRAME_W-1:0] frame;
        logic [3:0] left;
        logic bit_r;
        logic ufl_done;
        logic ufl;
    } mcf_tx_t;

    mcf_tx_t s;
    mcf_tx_t n;
    logic need;

    function automatic logic [FRAME_W-1:0] frame_of(input logic [7:0] d, input logic asy,
        input logic eight, input logic pen, input logic podd);
        logic [FRAME_W-1:0] f;
        logic p;
        f = '1;
        p = (^(eight ? d : {1'b0, d[6:0]})) ^ podd;
        if (!asy)
        begin
            f[7:0] = d;
        end
        else
        begin
            f[0] = SPACE;
            f[7:1] = d[6:0];
            if (eight)
            begin
                f[8] = d[7];
                if (pen)
                    f[9] = p;
            end
            else if (pen)
                f[8] = p;
        end
        return f;
    endfunction

    function automatic logic [3:0] len_of(input logic asy, input logic eight,
        input logic pen, input logic [1:0] sel);
        logic [3:0] l;
        l = START_BITS + (eight ? DATA_BITS_8 : DATA_BITS_7) + (pen ? PAR_BITS : 4'h0);
        if (sel == 2'h1)
            l = l + STOP_ONE;
        else if (sel[1])
            l = l + STOP_TWO;
        return asy ? l : SYNC_BITS;
    endfunction

    // Next character wanted at this bit tick
    assign need = lk.baud_tick && !(s.st == T_SEND && s.left > 4'h1);
    assign lk.tx_take = need && lk.tx_en && lk.tx_avail;
    assign lk.tx_underflow = s.ufl;
    assign lk.tx_bit = s.bit_r;

    always_comb
    begin
        n = s;
        n.ufl = 1'b0;
        if (lk.baud_tick)
        begin
            if (!lk.tx_en)
            begin
                n.st = T_IDLE;
                n.bit_r = MARK;
            end
            else if (!need)
            begin
                n.frame = {MARK, s.frame[FRAME_W-1:1]};
                n.left = s.left - 4'h1;
                n.bit_r = s.frame[1];
            end
            else if (lk.tx_avail)
            begin
                n.frame = frame_of(lk.tx_data, lk.async_mode, lk.eight_bits, lk.par_en,
                    lk.par_odd);
                n.left = len_of(lk.async_mode, lk.eight_bits, lk.par_en, lk.stop_sel);
                n.bit_r = n.frame[0];
                n.st = T_SEND;
                n.ufl_done = 1'b0;
            end
            else
            begin
                n.st = T_IDLE;
                n.bit_r = MARK;
                n.ufl = !s.ufl_done;
                n.ufl_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '{st: T_IDLE, frame: '1, left: 4'h0, bit_r: MARK, ufl_done: 1'b0, ufl: 1'b0};
        else
            s <= n;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_take_async;
        lk.tx_take && lk.async_mode;
    endsequence

    a_sync_length: assert property (lk.tx_take && !lk.async_mode |=> s.left == SYNC_BITS)
        else $error("sync frame is not eight bits");
    a_start_space: assert property (seq_take_async |=> !lk.tx_bit)
        else $error("async start bit is not space");
    a_off_mark: assert property (lk.baud_tick && !lk.tx_en |=> lk.tx_bit && !lk.tx_underflow)
        else $error("line not mark while transmit disabled");
    a_ufl_mark: assert property (lk.tx_underflow |-> lk.tx_bit ##1 !lk.tx_underflow)
        else $error("underflow without mark");
endmodule

// file: dv/mcf_host_model.sv
`timescale 1ns/1ps
module mcf_host_model
(
    input wire logic reply_i,
    input wire logic reply_oe_n_i,
    output logic sel_n_o,
    output logic sclk_o,
    output logic cmd_o
);
    initial
    begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        cmd_o = 1'b0;
    end

    // Address byte then data or reply byte, MSB first; sclk idles low
    task automatic xfer(input logic [15:0] sh, input int n, output logic [7:0] r);
        r = 8'h00;
        sel_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            cmd_o = sh[15-i];
            #62.5 sclk_o = 1'b1;
            #62.5 r = {r[6:0], reply_oe_n_i ? 1'bx : reply_i};
            sclk_o = 1'b0;
        end
        cmd_o = ~cmd_o;
        #62.5 sel_n_o = 1'b1;
        #250;
    endtask
endmodule

// file: dv/mcf_top_tb.sv
`timescale 1ns/1ps
module mcf_top_tb
    import mcf_pkg::*;
;
    localparam int BD = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rx_lb = 1'b1;
    logic rx_drv = 1'b1;
    logic sel_n, sclk, cmd, reply, reply_oe_n, tx_bit, relay, relay_oe_n, det_h, det_l;
    int mismatches = 0;
    int tests_run = 0;

    always #5 clk_i = ~clk_i;

    mcf_top #(.BAUD_DIV(BD)) dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cbus_sel_n_i(sel_n),
        .cbus_clk_i(sclk),
        .cbus_cmd_i(cmd),
        .cbus_reply_o(reply),
        .cbus_reply_oe_n_o(reply_oe_n),
        .rx_bit_i(rx_lb ? tx_bit : rx_drv),
        .tx_bit_o(tx_bit),
        .relay_pulldown_pin_o(relay),
        .relay_pulldown_pin_oe_n_o(relay_oe_n),
        .detection_mode_high_o(det_h),
        .detection_mode_low_o(det_l)
    );

    mcf_host_model host_u (
        .reply_i(reply),
        .reply_oe_n_i(reply_oe_n),
        .sel_n_o(sel_n),
        .sclk_o(sclk),
        .cmd_o(cmd)
    );

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer({a, d}, 16, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] r;
        host_u.xfer({a, 8'h00}, 16, r);
        chk({8'h00, r & m}, {8'h00, e});
    endtask

    // Finds the first space on the line, then samples 12 bits mid-bit
    task automatic cap(output logic [11:0] f);
        int k;
        k = 0;
        while (tx_bit !== 1'b0 && k < 600)
        begin
            @(negedge clk_i);
            k++;
        end
        repeat (BD / 2) @(negedge clk_i);
        for (int i = 0; i < 12; i++)
        begin
            f[i] = tx_bit;
            repeat (BD) @(negedge clk_i);
        end
    endtask

    task automatic sendf(input logic [11:0] f);
        @(negedge clk_i);
        for (int i = 0; i < 12; i++)
        begin
            rx_drv = f[i];
            repeat (BD) @(negedge clk_i);
        end
    endtask

    task automatic t_reset_state();
        chk({11'h0, relay, reply_oe_n, relay_oe_n, det_h, det_l}, 16'h000C);
        chk({15'h0, tx_bit}, 16'h0001);
    endtask

    // Async 8 bits, even parity, one stop, looped back into the receiver
    task automatic t_async_tx();
        logic [11:0] f;
        wr(ADR_MODE, 8'h2D);
        wr(ADR_TXDATA, 8'hA5);
        // Receiver ran in sync mode since reset: all-mark bytes, overflowed
        rd(ADR_FLAGS, 8'h1E, 8'h18);
        rd(ADR_RXDATA, 8'hFF, 8'hFF);
        chk({15'h0, tx_bit}, 16'h0001);
        fork
            wr(ADR_TXPSK, 8'h40);
            cap(f);
        join
        chk({4'h0, f}, {4'h0, 2'b11, 1'b0, 8'hA5, 1'b0});
        rd(ADR_FLAGS, 8'h9E, 8'h0E);
        rd(ADR_RXDATA, 8'hFF, 8'hA5);
    endtask

    task automatic t_rx_errs();
        @(negedge clk_i);
        rx_lb = 1'b0;
        sendf({3'b111, 1'b0, 8'h5A, 1'b0});
        rd(ADR_FLAGS, 8'h88, 8'h08);
        sendf({3'b111, 1'b0, 8'h01, 1'b0});
        rd(ADR_FLAGS, 8'h98, 8'h98);
        rd(ADR_RXDATA, 8'hFF, 8'h01);
        rd(ADR_FLAGS, 8'h98, 8'h00);
        @(negedge clk_i);
        rx_lb = 1'b1;
    endtask

    task automatic t_sync_tx();
        logic [11:0] f;
        wr(ADR_MODE, 8'h00);
        fork
            wr(ADR_TXDATA, 8'h3C);
            cap(f);
        join
        chk({4'h0, f}, 16'h0F3C);
    endtask

    task automatic t_setup();
        logic [7:0] r;
        wr(ADR_RXPSK, 8'h02);
        for (int d = 0; d < 4; d++)
        begin
            wr(ADR_SETUP, {2'b01, 2'(d), 4'h0});
            chk({13'h0, relay_oe_n, det_h, det_l}, {14'h0, 2'(d)});
        end
        host_u.xfer({ADR_RESET, 8'h00}, 8, r);
        chk({13'h0, relay_oe_n, det_h, det_l}, 16'h0004);
        chk({15'h0, tx_bit}, 16'h0001);
    endtask

    initial
    begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        t_reset_state();
        t_async_tx();
        t_rx_errs();
        t_sync_tx();
        t_setup();
        conclude();
    end

    initial
    begin
        #500_000;
        mismatches++;
        conclude();
    end
endmodule

// file: include/mcf_link_if.sv
`timescale 1ns/1ps
interface mcf_link_if;
    logic baud_tick;
    logic async_mode;
    logic eight_bits;
    logic par_en;
    logic par_odd;
    logic [1:0] stop_sel;
    logic tx_en;
    logic tx_avail;
    logic [7:0] tx_data;
    logic tx_take;
    logic tx_underflow;
    logic tx_bit;
    logic rx_bit;
    logic rx_load;
    logic [7:0] rx_data;
    logic rx_perr;

    modport top (
        output baud_tick, async_mode, eight_bits, par_en, par_odd, stop_sel,
        output tx_en, tx_avail, tx_data, rx_bit,
        input tx_take, tx_underflow, tx_bit, rx_load, rx_data, rx_perr
    );
    modport tx (
        input baud_tick, async_mode, eight_bits, par_en, par_odd, stop_sel,
        input tx_en, tx_avail, tx_data,
        output tx_take, tx_underflow, tx_bit
    );
    modport rx (
        input baud_tick, async_mode, eight_bits, par_en, par_odd, rx_bit,
        output rx_load, rx_data, rx_perr
    );
endinterface

// file: include/mcf_pkg.sv
package mcf_pkg;
    // Host bus addresses
    localparam logic [7:0] ADR_RESET = 8'h01;
    localparam logic [7:0] ADR_SETUP = 8'hE0;
    localparam logic [7:0] ADR_TONES = 8'hE1;
    localparam logic [7:0] ADR_GAIN = 8'hE2;
    localparam logic [7:0] ADR_TXDATA = 8'hE3;
    localparam logic [7:0] ADR_MODE = 8'hE4;
    localparam logic [7:0] ADR_TXPSK = 8'hE7;
    localparam logic [7:0] ADR_RXPSK = 8'hE8;
    localparam logic [7:0] ADR_IRQMASK = 8'hEE;
    localparam logic [7:0] ADR_RXDATA = 8'hE5;
    localparam logic [7:0] ADR_FLAGS = 8'hE6;
    localparam logic [7:0] REG_RST_VAL = 8'h00;

    // Field positions
    localparam int MODE_EIGHT = 0;
    localparam int MODE_PODD = 1;
    localparam int MODE_PEN = 2;
    localparam int MODE_STOPA = 3;
    localparam int MODE_STOPB = 4;
    localparam int MODE_ASYNC = 5;
    localparam int TXPSK_TXON = 6;
    localparam int SETUP_RELAY = 6;
    localparam int SETUP_DETH = 5;
    localparam int SETUP_DETL = 4;
    localparam int FLG_TXRDY = 1;
    localparam int FLG_UFL = 2;
    localparam int FLG_RXRDY = 3;
    localparam int FLG_OFL = 4;
    localparam int FLG_PERR = 7;

    // Bit counts
    localparam logic [3:0] CBUS_BITS = 4'h8;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] DATA_BITS_7 = 4'h7;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] PAR_BITS = 4'h1;
    localparam logic [3:0] STOP_ONE = 4'h1;
    localparam logic [3:0] STOP_TWO = 4'h2;
    localparam logic SPACE = 1'b0;
    localparam logic MARK = 1'b1;
    localparam int FRAME_W = 12;

    // Bit rate
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int BIT_RATE_BPS = 1200;
    localparam int BAUD_DIV_DEF = CLK_FREQ_HZ / BIT_RATE_BPS;
    localparam int BAUD_W = 17;

    typedef enum logic [4:0] {
        C_IDLE = 5'h01,
        C_ADDR = 5'h02,
        C_WDATA = 5'h04,
        C_REPLY = 5'h08,
        C_DONE = 5'h10
    } mcf_cbus_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'h1,
        T_SEND = 2'h2
    } mcf_txst_t;

    typedef enum logic [1:0] {
        R_HUNT = 2'h1,
        R_DATA = 2'h2
    } mcf_rxst_t;
endpackage
